// ===== hdl/dis_top.sv
// Debounced eight-channel input serializer with Avalon-MM status access.
// Assumes link pins and field inputs are asynchronous and are synchronised here.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dis_top #(
	parameter int DB_LONG  = dis_pkg::DB_LONG_CYC,
	parameter int DB_SHORT = dis_pkg::DB_SHORT_CYC
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	input  wire logic [7:0]              field_inputs,
	input  wire logic                    debounce_sel0,
	input  wire logic                    debounce_sel1,
	input  wire dis_pkg::dis_link_s      link_in,
	output logic                         serial_chain_out,
	output logic                         serial_chain_out_oe_n,
	output logic                         overtemp_flag_n,
	output logic                         overtemp_flag_oe_n,
	input  wire logic [3:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	output logic                         irq
);
	import dis_pkg::*;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [7:0]  field_s1;
	logic [7:0]  field_s2;
	dis_link_s   link_s1;
	dis_link_s   link_s2;
	logic [1:0]  sel_s1;
	logic [1:0]  sel_s2;
	logic        sclk_d;

	// Field levels
	always_ff @(posedge clk_sys) begin
		field_s1 <= field_inputs;
		field_s2 <= field_s1;
	end

	// Link pins
	always_ff @(posedge clk_sys) begin
		link_s1 <= link_in;
		link_s2 <= link_s1;
	end

	// Debounce select pins
	always_ff @(posedge clk_sys) begin
		sel_s1 <= {debounce_sel1, debounce_sel0};
		sel_s2 <= sel_s1;
	end

	// ---------------------------------------------------------------
	// Link clock edge detect
	// ---------------------------------------------------------------
	// Starts at the idle level of the link clock, so reset gives no false edge
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= link_s2.shift_clk;
		end
	end

	// ---------------------------------------------------------------
	// Debounce filters
	// ---------------------------------------------------------------
	logic [7:0]  latched_field_bits;
	dis_sel_e    db_sel;
	logic [31:0] db_limit;

	assign db_sel = dis_sel_e'(sel_s2);

	function automatic logic [31:0] db_cycles(input dis_sel_e sel, input int lng, input int sht);
		case (sel)
			DIS_SEL_LONG:  db_cycles = 32'(lng);
			DIS_SEL_SHORT: db_cycles = 32'(sht);
			default:       db_cycles = 32'h0000_0000;
		endcase
	endfunction

	assign db_limit = db_cycles(db_sel, DB_LONG, DB_SHORT);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_db
			logic [31:0] cnt;
			logic [31:0] next_cnt;
			logic        differs;
			logic        expired;

			assign differs = field_s2[gi] != latched_field_bits[gi];
			assign expired = db_sel == DIS_SEL_BYPASS || cnt + 32'h1 >= db_limit;

			// Counter restarts whenever the input returns to the latched level
			always_comb begin
				next_cnt = cnt;
				if (!differs || expired) begin
					next_cnt = 32'h0000_0000;
				end else begin
					next_cnt = cnt + 32'h1;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					cnt <= 32'h0000_0000;
				end else begin
					cnt <= next_cnt;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					latched_field_bits[gi] <= 1'b0;
				end else if (differs && expired) begin
					latched_field_bits[gi] <= field_s2[gi];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Shift register
	// ---------------------------------------------------------------
	logic [7:0]  shreg;
	logic [7:0]  next_shreg;
	logic        shift_edge;
	logic [4:0]  shift_count;

	assign shift_edge = link_s2.shift_clk && !sclk_d;

	// Shift mode: strobe high, enable low and a rising link clock
	function automatic logic shift_go(input dis_link_s lnk, input logic rise);
		shift_go = lnk.strobe_n && !lnk.clk_en_n && rise;
	endfunction

	always_comb begin
		next_shreg = shreg;
		if (!link_s2.strobe_n) begin
			next_shreg = latched_field_bits;
		end else if (shift_go(link_s2, shift_edge)) begin
			next_shreg = {shreg[NUM_CH-2:0], link_s2.chain_in};
		end else begin
			next_shreg = shreg;
		end
	end

	// Ones after reset, as an idle chain end returns
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			shreg <= 8'hff;
		end else begin
			shreg <= next_shreg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b || !link_s2.strobe_n) begin
			shift_count <= 5'h00;
		end else if (shift_go(link_s2, shift_edge) && shift_count != 5'h1f) begin
			shift_count <= shift_count + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// Temperature and pin drivers
	// ---------------------------------------------------------------
	logic        over_temp;
	logic        shutdown;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			serial_chain_out <= 1'b1;
		end else begin
			serial_chain_out <= shreg[NUM_CH-1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			serial_chain_out_oe_n <= 1'b0;
		end else begin
			serial_chain_out_oe_n <= shutdown;
		end
	end

	// Driven low in shutdown stands in for the pulldown
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			overtemp_flag_n <= 1'b1;
		end else begin
			overtemp_flag_n <= !(over_temp || shutdown);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			overtemp_flag_oe_n <= 1'b0;
		end else begin
			overtemp_flag_oe_n <= shutdown;
		end
	end

	// ---------------------------------------------------------------
	// Avalon-MM slave
	// ---------------------------------------------------------------
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [7:0]       field_hist;
	logic             over_d;
	logic             shdn_d;
	logic             rd_stat;
	logic             bus_ack;

	// One-cycle pulse for each event source
	always_comb begin
		irq_event                 = '0;
		irq_event[IRQ_CHANGE_BIT] = latched_field_bits != field_hist;
		irq_event[IRQ_OVER_BIT]   = over_temp && !over_d;
		irq_event[IRQ_SHDN_BIT]   = shutdown && !shdn_d;
	end

	assign rd_stat = avs_read && bus_ack && avs_address == ADDR_STATUS;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			field_hist <= 8'h00;
		end else begin
			field_hist <= latched_field_bits;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			over_d <= 1'b0;
		end else begin
			over_d <= over_temp;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			shdn_d <= 1'b0;
		end else begin
			shdn_d <= shutdown;
		end
	end

	// One wait cycle, then acknowledge
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bus_ack <= 1'b0;
		end else if ((avs_read || avs_write) && !bus_ack) begin
			bus_ack <= 1'b1;
		end else begin
			bus_ack <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && !bus_ack) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Control and mask registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			over_temp <= 1'b0;
			shutdown  <= 1'b0;
		end else if (avs_write && bus_ack && avs_address == ADDR_CTRL) begin
			over_temp <= avs_writedata[CTRL_OVER_BIT];
			shutdown  <= avs_writedata[CTRL_SHDN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_mask <= '0;
		end else if (avs_write && bus_ack && avs_address == ADDR_MASK) begin
			irq_mask <= avs_writedata[IRQ_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------
	// Only the bits handed out are cleared, so an event that lands between
	// capture and clear survives; events win over the clear
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_stat <= '0;
		end else if (rd_stat) begin
			irq_stat <= (irq_stat & ~avs_readdata[IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat <= irq_stat | irq_event;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			avs_readdata <= UNMAPPED_DATA;
		end else if ((avs_read || avs_write) && !bus_ack) begin
			case (avs_address)
				ADDR_FIELD:  avs_readdata <= {16'h0000, shreg, latched_field_bits};
				ADDR_SHIFT:  avs_readdata <= {29'h0, irq_mask};
				ADDR_CTRL:   avs_readdata <= {27'h0, shift_count[4:3] != 2'b00, db_sel, shutdown, over_temp};
				ADDR_STATUS: avs_readdata <= {29'h0, irq_stat};
				default:     avs_readdata <= UNMAPPED_DATA;
			endcase
		end
	end

endmodule

// ===== shared/dis_pkg.sv
// Constants, types and register map of the debounced input serializer.
// Assumes a 200 MHz system clock; link pins are asynchronous to it.
// Summary of operation
// - Input change accepted after stable debounce interval
// - Select pins pick 3 ms, 1 ms, bypass
// - Eight-stage parallel-in serial-out register drives output
// - Load strobe low loads debounced bits continuously
// - Load strobe high blocks parallel loading
// - Shift on rising link clock, enable low
// - Enable high holds register unchanged
// - Stages move toward output, first takes input
// - After eight shifts output follows serial input
// - Over-temperature flag low above first trip
// - All outputs float above second trip; irq and the Avalon-MM outputs stay driven here
// - Shutdown floats flag, pulldown keeps it low
package dis_pkg;

	localparam int          CLK_MHZ         = 200;
	localparam int          NUM_CH          = 8;
	localparam int          DB_LONG_MS      = 3;
	localparam int          DB_SHORT_MS     = 1;
	localparam int          DB_LONG_CYC     = DB_LONG_MS * CLK_MHZ * 1000;
	localparam int          DB_SHORT_CYC    = DB_SHORT_MS * CLK_MHZ * 1000;
	localparam int          CNT_W           = 20;

	// Avalon register byte addresses
	localparam logic [3:0]  ADDR_FIELD      = 4'h0;
	localparam logic [3:0]  ADDR_SHIFT      = 4'h4;
	localparam logic [3:0]  ADDR_CTRL       = 4'h8;
	localparam logic [3:0]  ADDR_STATUS     = 4'hc;
	localparam logic [3:0]  ADDR_MASK       = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_STAT   = 4'hc;

	// Control register fields
	localparam int          CTRL_OVER_BIT   = 0;
	localparam int          CTRL_SHDN_BIT   = 1;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

	// Interrupt status bits
	localparam int          IRQ_CHANGE_BIT  = 0;
	localparam int          IRQ_OVER_BIT    = 1;
	localparam int          IRQ_SHDN_BIT    = 2;
	localparam int          IRQ_W           = 3;

	typedef enum logic [1:0] {
		DIS_SEL_RESERVED = 2'b00,
		DIS_SEL_BYPASS   = 2'b01,
		DIS_SEL_SHORT    = 2'b10,
		DIS_SEL_LONG     = 2'b11
	} dis_sel_e;

	typedef enum logic [1:0] {
		DIS_BUS_IDLE = 2'b00,
		DIS_BUS_ACK  = 2'b01
	} dis_bus_e;

	typedef struct packed {
		logic strobe_n;
		logic clk_en_n;
		logic shift_clk;
		logic chain_in;
	} dis_link_s;

endpackage

// ===== tb/dis_props.sv
// Concurrent checks on the serializer top ports.
// Assumes it is bound into dis_top, one clock domain.
`timescale 1ns/1ps
module dis_props (
	input wire logic               clk_sys,
	input wire logic               rst_b,
	input wire logic [7:0]         field_inputs,
	input wire logic               debounce_sel0,
	input wire logic               debounce_sel1,
	input wire dis_pkg::dis_link_s link_in,
	input wire logic               serial_chain_out,
	input wire logic               serial_chain_out_oe_n,
	input wire logic               overtemp_flag_n,
	input wire logic               overtemp_flag_oe_n,
	input wire logic [3:0]         avs_address,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_writedata,
	input wire logic               avs_waitrequest
);
	import dis_pkg::*;
	logic over_q;
	logic shdn_q;
	// ----
	// Temperature state last written
	// ----
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			over_q <= 1'h0;
			shdn_q <= 1'h0;
		end else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL) begin
			over_q <= avs_writedata[CTRL_OVER_BIT];
			shdn_q <= avs_writedata[CTRL_SHDN_BIT];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_load;
		(!link_in.strobe_n && {debounce_sel1, debounce_sel0} == 2'h1 && $stable(field_inputs)
			&& !serial_chain_out_oe_n) [*8] |-> serial_chain_out == field_inputs[7];
	endproperty
	property p_hold;
		(link_in.strobe_n && link_in.clk_en_n && !serial_chain_out_oe_n) [*6]
			|=> $stable(serial_chain_out) || serial_chain_out_oe_n;
	endproperty
	property p_hot; (over_q || shdn_q) [*3] |-> !overtemp_flag_n; endproperty
	property p_cool; (!over_q && !shdn_q) [*3] |-> overtemp_flag_n; endproperty
	property p_float; shdn_q [*3] |-> serial_chain_out_oe_n && overtemp_flag_oe_n; endproperty
	property p_drive; !shdn_q [*3] |-> !serial_chain_out_oe_n && !overtemp_flag_oe_n; endproperty
	property p_pull; overtemp_flag_oe_n |-> !overtemp_flag_n; endproperty
	property p_wait; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
	a_load: assert property (p_load) else $error("load bit wrong");
	a_hold: assert property (p_hold) else $error("output moved while disabled");
	a_hot: assert property (p_hot) else $error("flag not low when hot");
	a_cool: assert property (p_cool) else $error("flag low when cool");
	a_float: assert property (p_float) else $error("outputs driven in shutdown");
	a_drive: assert property (p_drive) else $error("outputs floating");
	a_pull: assert property (p_pull) else $error("floating flag not low");
	a_wait: assert property (p_wait) else $error("waitrequest low too long");
	c_shift: cover property (link_in.strobe_n && !link_in.clk_en_n && link_in.shift_clk);
	c_shdn: cover property (shdn_q && serial_chain_out_oe_n);
	c_hot: cover property (over_q && !overtemp_flag_n);
endmodule
bind dis_top dis_props chk_u (.clk_sys, .rst_b, .field_inputs, .debounce_sel0, .debounce_sel1, .link_in,
	.serial_chain_out, .serial_chain_out_oe_n, .overtemp_flag_n, .overtemp_flag_oe_n, .avs_address,
	.avs_write, .avs_writedata, .avs_waitrequest);

// ===== tb/dis_host_model.sv
// Host end of the serial link: loads, shifts and reads frames.
// Assumes the block samples the link pins with its own clock.
`timescale 1ns/1ps
module dis_host_model (
	output dis_pkg::dis_link_s link_in,
	input  wire logic          serial_chain_out
);
	import dis_pkg::*;
	// Idle: clock still, chain end pulled high
	initial link_in = '{strobe_n: 1'h1, clk_en_n: 1'h1, shift_clk: 1'h0, chain_in: 1'h1};
	task automatic pulse;
		link_in.shift_clk = 1'h1;
		#24;
		link_in.shift_clk = 1'h0;
		#24;
	endtask
	task automatic frame(input int nbits, input int hold, input logic chain, output logic [31:0] bits);
		bits = 32'h0;
		link_in.strobe_n = 1'h0;
		#48;
		link_in.strobe_n = 1'h1;
		link_in.chain_in = chain;
		#24;
		link_in.clk_en_n = 1'h0;
		#24;
		for (int i = 0; i < nbits; i++) begin
			bits = {bits[30:0], serial_chain_out};
			if (i == 3) begin
				link_in.clk_en_n = 1'h1;
				#24;
				repeat (hold) pulse();
				link_in.clk_en_n = 1'h0;
				#24;
			end
			pulse();
		end
		link_in.clk_en_n = 1'h1;
		link_in.chain_in = 1'h1;
	endtask
endmodule

// ===== tb/debounced_input_serializer_bench.sv
// Self-checking bench for the debounced input serializer.
// Assumes dis_top, its bound checker and the host link model.
`timescale 1ns/1ps
module debounced_input_serializer_bench;
	import dis_pkg::*;
	localparam int LONG  = 20;
	localparam int SHORT = 8;
	logic        clk_sys = 1'h0;
	logic        rst_b = 1'h0;
	logic [7:0]  field_inputs = 8'h00;
	logic        debounce_sel0 = 1'h1;
	logic        debounce_sel1 = 1'h1;
	dis_link_s   link_in;
	logic        serial_chain_out;
	logic        serial_chain_out_oe_n;
	logic        overtemp_flag_n;
	logic        overtemp_flag_oe_n;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic [31:0] q;
	int          errors = 0;
	int          n_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	dis_top #(.DB_LONG(LONG), .DB_SHORT(SHORT)) dut_u (.clk_sys, .rst_b, .field_inputs, .debounce_sel0,
		.debounce_sel1, .link_in, .serial_chain_out, .serial_chain_out_oe_n, .overtemp_flag_n,
		.overtemp_flag_oe_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .irq);
	dis_host_model host_u (.link_in, .serial_chain_out);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		if (n >= 50) chk("bus answer", 32'h0, 32'h1);
	endtask
	// ----
	// Tests
	// ----
	task automatic t_debounce;
		logic [1:0] sel [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
		int         lim [4] = '{LONG, SHORT, 0, 0};
		logic [7:0] v [4] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3};
		logic [7:0] prev;
		prev = 8'h00;
		for (int i = 0; i < 4; i++) begin
			{debounce_sel1, debounce_sel0} <= sel[i];
			repeat (4) @(posedge clk_sys);
			field_inputs <= v[i];
			if (lim[i] > 0) begin
				repeat (lim[i] / 2) @(posedge clk_sys);
				bus(1'h0, ADDR_FIELD, 32'h0);
				chk("early bits", 32'(prev), 32'(q[7:0]));
			end
			repeat (lim[i] + 6) @(posedge clk_sys);
			bus(1'h0, ADDR_FIELD, 32'h0);
			chk("settled bits", 32'(v[i]), 32'(q[7:0]));
			prev = v[i];
		end
		$display("debounce test done");
	endtask
	task automatic t_frame(input logic chain);
		logic [31:0] bits;
		logic [7:0]  f;
		f = field_inputs;
		fork
			host_u.frame(16, 3, chain, bits);
			begin
				repeat (30) @(posedge clk_sys);
				field_inputs <= ~f;
			end
		join
		chk("frame", {16'h0, f, {8{chain}}}, bits);
		chk("paired channel", 32'(f[7]), 32'(bits[15] & bits[14]));
		$display("frame test done");
	endtask
	task automatic t_temp;
		bus(1'h1, 4'h4, 32'h2);
		bus(1'h0, 4'h4, 32'h0);
		chk("mask", 32'h2, q);
		bus(1'h0, ADDR_STATUS, 32'h0);
		bus(1'h1, ADDR_CTRL, 32'h1);
		repeat (4) @(posedge clk_sys);
		chk("hot", 32'h4, 32'({irq, overtemp_flag_n, serial_chain_out_oe_n}));
		bus(1'h0, ADDR_STATUS, 32'h0);
		chk("status", 32'h2, q & 32'h7);
		repeat (3) @(posedge clk_sys);
		chk("irq cleared", 32'h0, 32'(irq));
		bus(1'h1, ADDR_CTRL, 32'h3);
		repeat (4) @(posedge clk_sys);
		chk("shutdown", 32'h3, 32'({irq, overtemp_flag_n, serial_chain_out_oe_n, overtemp_flag_oe_n}));
		bus(1'h0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'h1, ADDR_CTRL, 32'h0);
		repeat (4) @(posedge clk_sys);
		chk("cool", 32'h4, 32'({overtemp_flag_n, serial_chain_out_oe_n, overtemp_flag_oe_n}));
		$display("temperature test done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		final_report;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		chk("reset outputs", 32'hb, 32'({avs_waitrequest, irq, overtemp_flag_n, serial_chain_out}));
		$display("reset test done");
		rst_b <= 1'h1;
		t_debounce;
		t_frame(1'h1);
		t_frame(1'h0);
		t_temp;
		final_report;
	end
endmodule
